//--- i2sw_bus_master.sv
// Behavioural bus master for the switch's two-wire target port.
// Assumes the bench resolves SDA as a pulled-up wire from sda_low and the target.
`timescale 1ns/1ps
`default_nettype none

module i2sw_bus_master (
    input wire logic clk_sys,
    input wire logic sda_line,
    output var logic scl,
    output var logic sda_low
);
    // Link clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic gap(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // SDA moves only mid-low, never beside an SCL edge
    task automatic clk_bit(input logic b, output logic s);
        gap(2);
        sda_low = !b;
        gap(2);
        scl = 1'b1;
        gap(2);
        s = sda_line;
        gap(2);
        scl = 1'b0;
    endtask

    task automatic start_cond();
        gap(2);
        sda_low = 1'b0;
        gap(2);
        scl = 1'b1;
        gap(4);
        sda_low = 1'b1;
        gap(4);
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        gap(2);
        sda_low = 1'b1;
        gap(2);
        scl = 1'b1;
        gap(4);
        sda_low = 1'b0;
        gap(4);
    endtask

    // Ninth bit always released: target acks writes, master naks reads
    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(tx[i], rx[i]);
        end
        clk_bit(1'b1, s);
        ack = !s;
    endtask

    task automatic access(input logic [6:0] addr, input logic rd, input logic [7:0] wdata,
                          output logic [7:0] rdata, output logic ack_a, output logic ack_d);
        logic [7:0] junk;
        rdata = 8'h00;
        ack_d = 1'b0;
        start_cond();
        byte_io({addr, rd}, junk, ack_a);
        if (ack_a) begin
            byte_io(rd ? 8'hFF : wdata, rdata, ack_d);
        end
    endtask
endmodule

`default_nettype wire

//--- i2sw_pkg.sv
// Shared constants, states and pin bundle for the bus-programmed switch.
// Assumes a single 40 MHz system clock; every pin arrives asynchronously.
package i2sw_pkg;

    // System clock
    localparam int CLK_PERIOD_NS = 25;

    // Internal non-volatile write duration and its cycle count
    localparam int NV_WRITE_TIME_NS = 10000;
    localparam int NV_WRITE_CYC = (NV_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Target address; value is arbitrary
    localparam logic [6:0] DEV_ADDR_DEF = 7'h2A;

    // Data byte layout
    localparam int RSVD_HI = 7;
    localparam int RSVD_LO = 5;
    localparam int LATCH_BIT = 4;
    localparam int MUX_HI = 3;
    localparam int SET_W = 5;
    localparam logic [2:0] RSVD_ZERO = 3'h0;
    localparam logic [SET_W-1:0] SET_FACTORY = 5'h00;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] MUX_ZERO = 4'h0;

    // Bus target states, Gray along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_AACK = 3'h3,
        ST_DATA = 3'h2,
        ST_DACK = 3'h6,
        ST_WAIT = 3'h7
    } i2sw_state_e;

    // Asynchronous pins, carried together through the synchroniser
    typedef struct packed {
        logic scl;
        logic sda;
        logic override_n;
        logic write_lock;
        logic source_select;
        logic supply_ok;
        logic [3:0] ext;
    } i2sw_pins_s;

    // Pulled-up pins idle high
    localparam i2sw_pins_s PINS_IDLE = 10'h3FF;

endpackage

//--- i2sw_switch.sv
// Bus-programmed configuration switch: I2C target, 5-bit stored setting,
// 4-bit two-way output multiplexer and one latched output bit.
// Assumes open-drain SDA resolved outside; all pins are asynchronous to clk_sys.
//
// Contract
// - Source-select low: selected outputs show the four low stored bits.
// - Source-select high: selected outputs show the external switch inputs.
// - Latched bit passes stored bit while select low, holds while high.
// - Held value equals the output at the select rising edge.
// - Force low with select low drives all outputs to zero.
// - Write-lock high refuses setting changes; low allows bus writes.
// - Data byte stored only for direction zero and write-lock low.
// - Direction one returns the stored setting in the data byte.
// - Transfer starts with fixed 7-bit address plus direction; answer only it.
// - Exactly one data byte follows the address acknowledge.
// - Byte layout: three zero bits, latched bit, four multiplexed bits.
// - Write aborts, setting unchanged, when any top three bits set.
// - Stored setting is all zeros as delivered.
// - Setting writes blocked while supply is below normal levels.
// - Write disables outputs after address ack; locked case re-enables after store or at the end of a refused byte.
// - Unlocked case re-enables outputs at the next START.
// - Force, lock, switch and select inputs read one while reset holds the synchroniser.
// - Reset initialises volatile state and the bus machine.
`timescale 1ns/1ps
`default_nettype none

module i2sw_switch #(
    parameter logic [6:0] DEV_ADDR = i2sw_pkg::DEV_ADDR_DEF,
    parameter int NV_WRITE_CYCLES = i2sw_pkg::NV_WRITE_CYC
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic override_n,
    input wire logic write_lock,
    input wire logic source_select,
    input wire logic supply_ok,
    input wire logic [3:0] external_switch_in,
    output logic [3:0] selected_out,
    output logic selected_out_oe,
    output logic latched_bit_out,
    output logic nv_busy
);
    import i2sw_pkg::*;

    i2sw_pins_s pins_raw;
    i2sw_pins_s sync1_reg;
    i2sw_pins_s sync2_reg;
    i2sw_pins_s prev_reg;
    i2sw_state_e state_reg;
    logic [3:0] cnt_reg;
    logic [7:0] shift_reg;
    logic is_read_reg;
    logic sda_oe_reg;
    logic [SET_W-1:0] nv_reg;
    logic [SET_W-1:0] nv_pend_reg;
    logic [15:0] nv_cnt_reg;
    logic nv_busy_reg;
    logic oe_reg;
    logic lock_at_wr_reg;
    logic [3:0] sel_out_reg;
    logic latched_reg;
    logic scl_rise, scl_fall, start_det, stop_det;
    logic wr_byte_end, accept_wr, nv_done, addr_wr_ack_end;
    logic [7:0] nv_byte;

    assign pins_raw = '{scl: scl_in, sda: sda_in, override_n: override_n,
                        write_lock: write_lock, source_select: source_select,
                        supply_ok: supply_ok, ext: external_switch_in};

    // Pull-up default
    // Synchroniser resets to all ones so pins read high until first sampled after reset
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sync1_reg <= PINS_IDLE;
            sync2_reg <= PINS_IDLE;
            prev_reg <= PINS_IDLE;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign scl_rise = sync2_reg.scl && !prev_reg.scl;
    assign scl_fall = !sync2_reg.scl && prev_reg.scl;
    // SDA changing while SCL stays high marks START and STOP
    assign start_det = sync2_reg.scl && prev_reg.scl && prev_reg.sda && !sync2_reg.sda;
    assign stop_det = sync2_reg.scl && prev_reg.scl && !prev_reg.sda && sync2_reg.sda;

    assign nv_byte = {RSVD_ZERO, nv_reg};

    assign wr_byte_end = (state_reg == ST_DATA) && !is_read_reg && scl_fall && (cnt_reg == BYTE_BITS);
    assign accept_wr = wr_byte_end && (shift_reg[RSVD_HI:RSVD_LO] == RSVD_ZERO) && !sync2_reg.write_lock
                       && sync2_reg.supply_ok && !nv_busy_reg;
    assign nv_done = nv_busy_reg && (nv_cnt_reg == 16'(NV_WRITE_CYCLES - 1));
    assign addr_wr_ack_end = (state_reg == ST_AACK) && scl_fall && !is_read_reg;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            is_read_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (start_det) begin
            state_reg <= ST_ADDR;
            cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
        end else if (stop_det) begin
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sync2_reg.sda};
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == BYTE_BITS) begin
                        cnt_reg <= 4'h0;
                        if (shift_reg[7:1] == DEV_ADDR) begin
                            state_reg <= ST_AACK;
                            is_read_reg <= shift_reg[0];
                            sda_oe_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_WAIT;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        state_reg <= ST_DATA;
                        if (is_read_reg) begin
                            shift_reg <= nv_byte;
                            sda_oe_reg <= !nv_byte[7];
                        end else begin
                            sda_oe_reg <= 1'b0;
                        end
                    end
                end
                ST_DATA: begin
                    if (scl_rise) begin
                        cnt_reg <= cnt_reg + 4'h1;
                        if (!is_read_reg) begin
                            shift_reg <= {shift_reg[6:0], sync2_reg.sda};
                        end
                    end else if (scl_fall) begin
                        if (cnt_reg == BYTE_BITS) begin
                            cnt_reg <= 4'h0;
                            state_reg <= ST_DACK;
                            // Ack written byte, release on read
                            sda_oe_reg <= !is_read_reg;
                        end else if (is_read_reg) begin
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            sda_oe_reg <= !shift_reg[6];
                        end
                    end
                end
                // Single data byte, then ignore until START or STOP
                ST_DACK: begin
                    if (scl_fall) begin
                        state_reg <= ST_WAIT;
                        sda_oe_reg <= 1'b0;
                    end
                end
                ST_IDLE, ST_WAIT: begin
                    sda_oe_reg <= 1'b0;
                end
                default: begin
                    state_reg <= ST_IDLE;
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // Non-volatile store
    // Reset reloads the factory value; real storage would survive power-down
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            nv_reg <= SET_FACTORY;
            nv_pend_reg <= SET_FACTORY;
            nv_cnt_reg <= 16'h0000;
            nv_busy_reg <= 1'b0;
        end else if (accept_wr) begin
            nv_pend_reg <= shift_reg[SET_W-1:0];
            nv_cnt_reg <= 16'h0000;
            nv_busy_reg <= 1'b1;
        end else if (nv_busy_reg) begin
            nv_cnt_reg <= nv_cnt_reg + 16'h0001;
            if (nv_done) begin
                nv_busy_reg <= 1'b0;
                // Supply low on the cycle the write completes discards it
                if (sync2_reg.supply_ok) begin
                    nv_reg <= nv_pend_reg;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            oe_reg <= 1'b1;
            lock_at_wr_reg <= 1'b0;
        end else if (addr_wr_ack_end) begin
            oe_reg <= 1'b0;
            lock_at_wr_reg <= sync2_reg.write_lock;
        end else if (!oe_reg) begin
            // Locked case also recovers at START so a cut-short write cannot stick
            if (start_det) begin
                oe_reg <= 1'b1;
            end else if (lock_at_wr_reg && (nv_done || (wr_byte_end && !accept_wr))) begin
                oe_reg <= 1'b1;
            end
        end
    end

    // Multiplexed outputs
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sel_out_reg <= MUX_ZERO;
        end else if (sync2_reg.source_select) begin
            sel_out_reg <= sync2_reg.ext;
        end else if (!sync2_reg.override_n) begin
            sel_out_reg <= MUX_ZERO;
        end else begin
            sel_out_reg <= nv_reg[MUX_HI:0];
        end
    end

    // Transparent while select low, holds last output when high
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            latched_reg <= 1'b0;
        end else if (!sync2_reg.source_select) begin
            latched_reg <= sync2_reg.override_n ? nv_reg[LATCH_BIT] : 1'b0;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_reg;
    assign selected_out = sel_out_reg;
    assign selected_out_oe = oe_reg;
    assign latched_bit_out = latched_reg;
    assign nv_busy = nv_busy_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_mux_stored_path: assert property (!sync2_reg.source_select && sync2_reg.override_n |=>
        selected_out == $past(nv_reg[MUX_HI:0])) else $error("stored path wrong");
    a_mux_ext_path: assert property (sync2_reg.source_select |=>
        selected_out == $past(sync2_reg.ext)) else $error("external path wrong");
    a_latch_hold: assert property (sync2_reg.source_select |=> $stable(latched_bit_out))
        else $error("latched bit moved while held");
    a_latch_capture: assert property ($rose(sync2_reg.source_select) |->
        latched_bit_out == ($past(sync2_reg.override_n) ? $past(nv_reg[LATCH_BIT]) : 1'b0))
        else $error("latched value not captured at select rise");
    a_force_zero: assert property (!sync2_reg.override_n && !sync2_reg.source_select |=>
        selected_out == MUX_ZERO && latched_bit_out == 1'b0) else $error("force did not zero outputs");
    a_lock_refuse: assert property (accept_wr |-> !sync2_reg.write_lock)
        else $error("write accepted while locked");
    a_write_dir: assert property (accept_wr |-> !is_read_reg && state_reg == ST_DATA)
        else $error("store outside write direction");
    a_read_first_bit: assert property ($past(state_reg == ST_AACK && scl_fall && is_read_reg)
        && state_reg == ST_DATA |-> sda_oe == !nv_byte[7] && shift_reg == {RSVD_ZERO, $past(nv_reg)})
        else $error("read byte not driven");
    a_addr_filter: assert property (state_reg == ST_ADDR && scl_fall && cnt_reg == BYTE_BITS
        && shift_reg[7:1] != DEV_ADDR && !start_det && !stop_det |=> state_reg == ST_WAIT && !sda_oe)
        else $error("foreign address answered");
    a_rsvd_abort: assert property (wr_byte_end && shift_reg[RSVD_HI:RSVD_LO] != RSVD_ZERO
        |-> !accept_wr) else $error("reserved bits not aborted");
    a_nv_cause: assert property (nv_reg != $past(nv_reg) |-> $past(nv_done && sync2_reg.supply_ok))
        else $error("setting changed without completed write");
    a_wr_disable: assert property (addr_wr_ack_end |=> !selected_out_oe)
        else $error("outputs not disabled after address ack");
    a_start_enable: assert property (!selected_out_oe && start_det && !addr_wr_ack_end
        |=> selected_out_oe) else $error("outputs not re-enabled at START");
    a_addr_ack: assert property ($rose(state_reg == ST_AACK) |-> sda_oe [*1] ##1 (sda_oe || scl_fall
        || state_reg != ST_AACK)) else $error("address not acknowledged");

    c_write_commit: cover property (accept_wr ##[1:1000] nv_done);
    c_read_byte: cover property (state_reg == ST_DATA && is_read_reg ##[1:1000] state_reg == ST_DACK);
    c_select_rise: cover property ($rose(sync2_reg.source_select));
    c_locked_write: cover property (wr_byte_end && sync2_reg.write_lock);

endmodule

`default_nettype wire

//--- i2sw_switch_tb.sv
// Self-checking bench for the bus-programmed switch.
// Assumes the behavioural master model drives the bus pins.
`timescale 1ns/1ps
`default_nettype none

module i2sw_switch_tb;
    import i2sw_pkg::*;
    localparam logic [6:0] ADDR = DEV_ADDR_DEF;
    localparam int NV_CYC = 8;
    logic clk_sys, nrst, scl, sda_low, sda_in, sda_out, sda_oe, override_n, write_lock;
    logic source_select, supply_ok, selected_out_oe, latched_bit_out, nv_busy, ack_a, ack_d;
    logic [3:0] external_switch_in, selected_out;
    logic [7:0] rdata;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int busy_cycles = 0;

    // Pulled-up wire
    assign sda_in = !(sda_low || (sda_oe && !sda_out));

    i2sw_switch #(.DEV_ADDR(ADDR), .NV_WRITE_CYCLES(NV_CYC)) u_dut (.clk_sys(clk_sys), .nrst(nrst),
        .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .override_n(override_n),
        .write_lock(write_lock), .source_select(source_select), .supply_ok(supply_ok),
        .external_switch_in(external_switch_in), .selected_out(selected_out),
        .selected_out_oe(selected_out_oe), .latched_bit_out(latched_bit_out), .nv_busy(nv_busy));

    i2sw_bus_master u_master (.clk_sys(clk_sys), .sda_line(sda_in), .scl(scl), .sda_low(sda_low));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (nv_busy === 1'b1) begin
            busy_cycles++;
        end
        if (cycles == 20000) begin
            n_errors++;
            $display("unexpected at %0t: run too long", $time);
            conclude();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic outs(input logic [3:0] es, input logic el);
        repeat (6) @(negedge clk_sys);
        chk({4'h0, selected_out}, {4'h0, es}, "mux outputs");
        chk({7'h00, latched_bit_out}, {7'h00, el}, "latched bit");
    endtask

    task automatic oe_is(input logic e);
        chk({7'h00, selected_out_oe}, {7'h00, e}, "output enable");
    endtask

    // Write, stop, wait out the store; busy_exp is the store length, 0 when refused
    task automatic wr(input logic [7:0] d, input int busy_exp);
        int k;
        int b0;
        k = 0;
        b0 = busy_cycles;
        u_master.access(ADDR, 1'b0, d, rdata, ack_a, ack_d);
        u_master.stop_cond();
        while (nv_busy !== 1'b0 && k < 200) begin
            @(negedge clk_sys);
            k++;
        end
        repeat (6) @(negedge clk_sys);
        chk(8'(busy_cycles - b0), 8'(busy_exp), "store cycles");
    endtask

    task automatic rd(input logic [7:0] exp);
        u_master.access(ADDR, 1'b1, 8'h00, rdata, ack_a, ack_d);
        u_master.stop_cond();
        chk(rdata, exp, "read byte");
        chk({7'h00, ack_a}, 8'h01, "address ack");
    endtask

    task automatic t_reset();
        outs(4'h0, 1'b0);
        oe_is(1'b1);
        chk({7'h00, sda_out}, 8'h00, "data drive level");
        rd(8'h00);
        $display("reset test done");
    endtask

    task automatic t_write();
        wr(8'h15, NV_CYC);
        chk({6'h00, ack_a, ack_d}, 8'h03, "write acks");
        oe_is(1'b0);
        rd(8'h15);
        oe_is(1'b1);
        outs(4'h5, 1'b1);
        $display("write test done");
    endtask

    task automatic t_refused();
        write_lock = 1'b1;
        wr(8'h0A, 0);
        oe_is(1'b1);
        write_lock = 1'b0;
        rd(8'h15);
        for (int b = 5; b <= 7; b++) begin
            wr(8'h0A | (8'h01 << b), 0);
        end
        rd(8'h15);
        supply_ok = 1'b0;
        wr(8'h0A, 0);
        supply_ok = 1'b1;
        rd(8'h15);
        u_master.access(ADDR ^ 7'h01, 1'b0, 8'h0A, rdata, ack_a, ack_d);
        u_master.stop_cond();
        chk({7'h00, ack_a}, 8'h00, "foreign ack");
        rd(8'h15);
        $display("refusal test done");
    endtask

    task automatic t_select();
        external_switch_in = 4'hC;
        source_select = 1'b1;
        outs(4'hC, 1'b1);
        wr(8'h03, NV_CYC);
        rd(8'h03);
        outs(4'hC, 1'b1);
        override_n = 1'b0;
        outs(4'hC, 1'b1);
        source_select = 1'b0;
        outs(4'h0, 1'b0);
        override_n = 1'b1;
        outs(4'h3, 1'b0);
        $display("select test done");
    endtask

    initial begin
        nrst = 1'b0;
        override_n = 1'b1;
        write_lock = 1'b0;
        source_select = 1'b0;
        supply_ok = 1'b1;
        external_switch_in = 4'hF;
        repeat (16) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (6) @(negedge clk_sys);
        t_reset();
        t_write();
        t_refused();
        t_select();
        conclude();
    end
endmodule

`default_nettype wire
